// >>> tfr_pkg.sv
// tfr_pkg: constants for the trigger frame counter and packet recorder
// assumes: single 40 MHz clock domain, used via tfr_pkg::name only
package tfr_pkg;
   // ***************************************************************
   // output modes
   // ***************************************************************
   localparam logic [1:0] MODE_STOP   = 2'h0;
   localparam logic [1:0] MODE_RECORD = 2'h1;
   localparam logic [1:0] MODE_STREAM = 2'h2;
   localparam logic [1:0] MODE_POLL   = 2'h3;
   // ***************************************************************
   // register map (word offsets are byte addresses)
   // ***************************************************************
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_LENGTH = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_FILL   = 8'h0C;
   localparam logic [7:0] REG_TOTAL  = 8'h10;
   localparam logic [7:0] REG_READ   = 8'h14;
   localparam logic [7:0] REG_CMD    = 8'h18;
   // ctrl fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_RING_BIT = 2;
   localparam int CTRL_TRIG_BIT = 3;
   // cmd fields (write pulses)
   localparam int CMD_IDLE_BIT  = 0;
   localparam int CMD_CLEAR_BIT = 1;
   // status fields
   localparam int STAT_ACTIVE_BIT = 0;
   localparam int STAT_EMPTY_BIT  = 1;
   localparam int STAT_REFUSE_BIT = 2;
   // ***************************************************************
   // sizes and reset values
   // ***************************************************************
   localparam int unsigned MAX_PACKETS = 10000000;
   localparam int unsigned LEN_QUANTUM = 32;
   localparam int          CNT_W       = 24;
   localparam int          FRAME_W     = 8;
   localparam logic [31:0] RESET_LEN   = 32'h0000_0020;
endpackage : tfr_pkg

// >>> tfr_frame_ctr.sv
// tfr_frame_ctr: one eight-bit frame counter per axis
// assumes: trigger pulses and clear commands are one cycle long
`timescale 1ns/1ps
`default_nettype none
module tfr_frame_ctr #(
   parameter int AXES = 4
) (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      count_en,
   input  wire logic                      trig,
   input  wire logic [AXES-1:0]           clear,
   output logic [AXES*tfr_pkg::FRAME_W-1:0] frame
);
   logic [tfr_pkg::FRAME_W-1:0] cnt_q [AXES];

   for (genvar a = 0; a < AXES; a++) begin : g_ax
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            cnt_q[a] <= 8'h00;
         end else if (clear[a] || !count_en) begin
            // stopped, polling or cleared: counter held at zero
            cnt_q[a] <= 8'h00;
         end else if (trig) begin
            // the packet carries the value before this step, so the
            // first trigger is tagged zero and the next one
            cnt_q[a] <= cnt_q[a] + 8'h01;
         end
      end
      assign frame[a*tfr_pkg::FRAME_W +: tfr_pkg::FRAME_W] = cnt_q[a];
   end
endmodule : tfr_frame_ctr
`default_nettype wire

// >>> tfr_store.sv
// tfr_store: packet memory, one write port, one read port
// assumes: caller keeps addresses inside DEPTH
`timescale 1ns/1ps
`default_nettype none
module tfr_store #(
   parameter int W     = 32,
   parameter int DEPTH = 1024,
   parameter int AW    = 10
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic [AW-1:0] raddr,
   output logic [W-1:0]       rdata
);
   logic [W-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (we)
         mem[waddr] <= wdata;
      rdata <= mem[raddr];
   end
endmodule : tfr_store
`default_nettype wire

// >>> tfr_recorder.sv
// tfr_recorder: trigger-driven frame counting and packet recording
// assumes: packet data and trigger pulses are synchronous to clk;
// software owns the register port.
//
// What this block does
// - frame counter is zero on first trigger, then adds one per trigger
// - frame counter wraps from 255 back to zero
// - in polling mode the frame counter stays at zero
// - clear command zeroes the frame counters of the addressed axes
// - packets are produced only on trigger events with trigger enabled
// - store holds at most ten million packets
// - single shot stops by itself when the area is full
// - ring mode overwrites oldest packet until host stops
// - host stop request ends single-shot recording early
// - readout only after recording stopped; refused while running
// - stored packets read out oldest first, ring unwrapped
// - record mode captures into RAM, network destination ignored
// - ring bit: 0 single shot, 1 ring buffer
// - length rounded down to multiple of 32, at least 32
// - stop mode ends streaming and recording
// - single shot full switches mode to stop by itself
// - fill climbs to length, holds in ring mode
// - active flag is 1 while recording, else 0
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module tfr_recorder #(
   parameter int AXES  = 4,
   parameter int PKT_W = 24,
   parameter int DEPTH = 1024,
   parameter int AW    = 10
) (
   input  wire logic                  clk,
   input  wire logic                  rst,
   // register port
   input  wire logic [7:0]            reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic [31:0]                reg_rdata,
   // trigger and packet source
   input  wire logic                  trig_in,
   input  wire logic [PKT_W-1:0]      pkt_data,
   output logic                       trig_enable,
   // network stream out
   output logic                       stream_valid,
   output logic [PKT_W+7:0]           stream_data,
   // frame counters per axis
   output logic [AXES*8-1:0]          frame_out
);
   // ***************************************************************
   // helpers
   // ***************************************************************
   function automatic logic [tfr_pkg::CNT_W-1:0] fit_len(
      input logic [31:0] req, input int unsigned cap);
      logic [31:0] r;
      r = {req[31:5], 5'h00};
      if (r < tfr_pkg::LEN_QUANTUM)
         r = tfr_pkg::LEN_QUANTUM;
      if (r > cap)
         r = cap & 32'hFFFF_FFE0;
      return r[tfr_pkg::CNT_W-1:0];
   endfunction

   function automatic logic [AW-1:0] wrap_inc(
      input logic [AW-1:0] p, input logic [tfr_pkg::CNT_W-1:0] len);
      logic [tfr_pkg::CNT_W-1:0] n;
      n = {{(tfr_pkg::CNT_W-AW){1'b0}}, p} + 24'h000001;
      return (n >= len) ? '0 : n[AW-1:0];
   endfunction

   // store cannot exceed either its array or the documented ceiling
   localparam int unsigned CAP =
      (DEPTH < tfr_pkg::MAX_PACKETS) ? DEPTH : tfr_pkg::MAX_PACKETS;

   // ***************************************************************
   // state
   // ***************************************************************
   logic [1:0]                 mode_q;
   logic                       ring_q;
   logic                       trig_en_q;
   logic [tfr_pkg::CNT_W-1:0]  len_q;
   logic [tfr_pkg::CNT_W-1:0]  fill_q;
   logic [AW-1:0]              wptr_q;
   logic [AW-1:0]              rptr_q;
   logic [tfr_pkg::CNT_W-1:0]  left_q;
   logic                       rd_pend_q;
   logic                       refused_q;
   logic [7:0]                 rd_addr_q;
   logic [31:0]                reg_rdata_q;
   logic [AXES-1:0]            clr_d;
   logic                       idle_cmd;
   logic                       wr_ctrl;
   logic                       wr_len;
   logic                       rd_pop;
   logic                       recording;
   logic                       pkt_ev;
   logic                       rec_we;
   logic                       full_single;
   logic [PKT_W+7:0]           pkt_word;
   logic [PKT_W+7:0]           mem_rdata;
   logic [AW-1:0]              raddr;
   logic [7:0]                 frame0;

   assign wr_ctrl  = reg_wr && reg_addr == tfr_pkg::REG_CTRL;
   assign wr_len   = reg_wr && reg_addr == tfr_pkg::REG_LENGTH;
   assign idle_cmd = reg_wr && reg_addr == tfr_pkg::REG_CMD
                     && reg_wdata[tfr_pkg::CMD_IDLE_BIT];
   assign clr_d    = (reg_wr && reg_addr == tfr_pkg::REG_CMD
                      && reg_wdata[tfr_pkg::CMD_CLEAR_BIT])
                     ? reg_wdata[8 +: AXES] : '0;
   assign recording = mode_q == tfr_pkg::MODE_RECORD;
   assign pkt_ev    = trig_in && trig_en_q;
   assign rec_we    = pkt_ev && recording;
   assign full_single = rec_we && !ring_q
                        && fill_q + 24'h000001 >= len_q;
   assign rd_pop    = reg_rd && reg_addr == tfr_pkg::REG_READ
                      && !recording && left_q != '0;
   assign trig_enable = trig_en_q;
   assign frame0    = frame_out[7:0];
   assign pkt_word  = {frame0, pkt_data};

   // ***************************************************************
   // configuration and mode
   // ***************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_q    <= tfr_pkg::MODE_STOP;
         ring_q    <= 1'b0;
         trig_en_q <= 1'b0;
      end else if (idle_cmd) begin
         mode_q    <= tfr_pkg::MODE_STOP;
         ring_q    <= 1'b0;
         trig_en_q <= 1'b0;
      end else if (full_single) begin
         // hardware stop beats a same-cycle control write; an idle command beats it
         mode_q <= tfr_pkg::MODE_STOP;
      end else if (wr_ctrl) begin
         mode_q    <= reg_wdata[tfr_pkg::CTRL_MODE_LSB +: 2];
         ring_q    <= reg_wdata[tfr_pkg::CTRL_RING_BIT];
         trig_en_q <= reg_wdata[tfr_pkg::CTRL_TRIG_BIT];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         len_q <= tfr_pkg::RESET_LEN[tfr_pkg::CNT_W-1:0];
      else if (wr_len && !recording)
         len_q <= fit_len(reg_wdata, CAP);
   end

   // ***************************************************************
   // recording pointers
   // ***************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wptr_q <= '0;
         fill_q <= '0;
      end else if (idle_cmd || (wr_ctrl && !recording
                 && reg_wdata[1:0] == tfr_pkg::MODE_RECORD)) begin
         // a fresh recording starts from an empty area
         wptr_q <= '0;
         fill_q <= '0;
      end else if (rec_we) begin
         wptr_q <= wrap_inc(wptr_q, len_q);
         if (fill_q < len_q)
            fill_q <= fill_q + 24'h000001;
      end
   end

   // ***************************************************************
   // readout, oldest first
   // ***************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rptr_q <= '0;
         left_q <= '0;
      end else if (idle_cmd || (rec_we && !full_single)) begin
         left_q <= '0;
      end else if (full_single || (wr_ctrl && recording
                 && reg_wdata[1:0] != tfr_pkg::MODE_RECORD)) begin
         // on stop: full ring starts at the write pointer
         left_q <= full_single ? len_q : fill_q;
         rptr_q <= (!full_single && fill_q >= len_q) ? wptr_q : '0;
      end else if (rd_pop) begin
         rptr_q <= wrap_inc(rptr_q, len_q);
         left_q <= left_q - 24'h000001;
      end
   end

   assign raddr = rptr_q;

   tfr_store #(
      .W     (PKT_W + 8),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_store (
      .clk   (clk),
      .we    (rec_we),
      .waddr (wptr_q),
      .wdata (pkt_word),
      .raddr (raddr),
      .rdata (mem_rdata)
   );

   // ***************************************************************
   // frame counters
   // ***************************************************************
   tfr_frame_ctr #(
      .AXES (AXES)
   ) u_frame (
      .clk      (clk),
      .rst      (rst),
      .count_en (mode_q == tfr_pkg::MODE_RECORD
                 || mode_q == tfr_pkg::MODE_STREAM),
      .trig     (pkt_ev),
      .clear    (clr_d),
      .frame    (frame_out)
   );

   // ***************************************************************
   // network stream
   // ***************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stream_valid <= 1'b0;
         stream_data  <= '0;
      end else begin
         // stop and record both keep the stream quiet
         stream_valid <= pkt_ev && mode_q == tfr_pkg::MODE_STREAM;
         if (pkt_ev)
            stream_data <= pkt_word;
      end
   end

   // ***************************************************************
   // register read
   // ***************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_pend_q <= 1'b0;
         rd_addr_q <= 8'h00;
         refused_q <= 1'b0;
      end else begin
         rd_pend_q <= reg_rd;
         rd_addr_q <= reg_addr;
         if (reg_rd && reg_addr == tfr_pkg::REG_READ && recording)
            refused_q <= 1'b1;
         else if (rd_pend_q && rd_addr_q == tfr_pkg::REG_STATUS)
            // cleared after the answer cycle so the read still shows it
            refused_q <= 1'b0;
      end
   end

   always_comb begin
      reg_rdata_q = 32'h0000_0000;
      case (rd_addr_q)
         tfr_pkg::REG_CTRL:
            reg_rdata_q = {28'h0, trig_en_q, ring_q, mode_q};
         tfr_pkg::REG_LENGTH,
         tfr_pkg::REG_TOTAL:
            reg_rdata_q = {8'h00, len_q};
         tfr_pkg::REG_STATUS:
            reg_rdata_q = {29'h0, refused_q, left_q == '0, recording};
         tfr_pkg::REG_FILL:
            reg_rdata_q = {8'h00, fill_q};
         tfr_pkg::REG_READ:
            reg_rdata_q = mem_rdata;
         default:
            reg_rdata_q = 32'h0000_0000;
      endcase
   end

   assign reg_rdata = rd_pend_q ? reg_rdata_q : 32'h0000_0000;
endmodule : tfr_recorder
`default_nettype wire

// >>> tfr_recorder_sva.sv
// tfr_recorder_sva: port-level checks bound into tfr_recorder
// assumes: one clock, register port and triggers as in the hand-over
`timescale 1ns/1ps
`default_nettype none
module tfr_recorder_sva #(
   parameter int AXES  = 4,
   parameter int PKT_W = 24,
   parameter int DEPTH = 1024
) (
   input wire logic              clk,
   input wire logic              rst,
   input wire logic [7:0]        reg_addr,
   input wire logic [31:0]       reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [31:0]       reg_rdata,
   input wire logic              trig_in,
   input wire logic [PKT_W-1:0]  pkt_data,
   input wire logic              trig_enable,
   input wire logic              stream_valid,
   input wire logic [PKT_W+7:0]  stream_data,
   input wire logic [AXES*8-1:0] frame_out
);
   // ***************************************************************
   // helper state
   // ***************************************************************
   logic [1:0] mode_q;
   logic [7:0] last_q;
   logic       seen_q;
   wire logic  ctrl_wr = reg_wr && reg_addr == tfr_pkg::REG_CTRL;
   wire logic  cmd_wr  = reg_wr && reg_addr == tfr_pkg::REG_CMD;
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         mode_q <= tfr_pkg::MODE_STOP;
      else if (cmd_wr && reg_wdata[tfr_pkg::CMD_IDLE_BIT])
         mode_q <= tfr_pkg::MODE_STOP;
      else if (ctrl_wr)
         mode_q <= reg_wdata[1:0];
   end
   // any config write restarts the sequence, so skip one comparison
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         seen_q <= 1'b0;
         last_q <= 8'h00;
      end else if (ctrl_wr || cmd_wr) begin
         seen_q <= 1'b0;
      end else if (stream_valid) begin
         seen_q <= 1'b1;
         last_q <= stream_data[PKT_W+7:PKT_W];
      end
   end
   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   a_read_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside answer cycle");
   a_stream_cause: assert property (
      stream_valid |-> $past(trig_in && trig_enable))
      else $error("stream word without accepted trigger");
   a_stream_payload: assert property (
      stream_valid |-> stream_data[PKT_W-1:0] == $past(pkt_data))
      else $error("stream payload differs from sampled packet");
   a_frame_step: assert property (
      stream_valid && seen_q |-> stream_data[PKT_W+7:PKT_W] == last_q + 8'h01)
      else $error("frame counter did not step by one");
   a_trig_follow: assert property (
      ctrl_wr |=> trig_enable == $past(reg_wdata[tfr_pkg::CTRL_TRIG_BIT]))
      else $error("trigger enable does not follow control write");
   a_idle_trig: assert property (
      cmd_wr && reg_wdata[tfr_pkg::CMD_IDLE_BIT] |=> !trig_enable)
      else $error("idle command left trigger enabled");
   a_clear_axis: assert property (
      cmd_wr && reg_wdata[tfr_pkg::CMD_CLEAR_BIT] && reg_wdata[8]
      |=> frame_out[7:0] == 8'h00)
      else $error("clear command left axis counter nonzero");
   a_len_round: assert property (
      reg_rd && reg_addr == tfr_pkg::REG_LENGTH |=> reg_rdata[4:0] == 5'h00
      && reg_rdata >= 32 && reg_rdata <= DEPTH)
      else $error("record length not a legal multiple of 32");
   a_poll_zero: assert property (
      mode_q == tfr_pkg::MODE_POLL && $past(mode_q) == tfr_pkg::MODE_POLL
      && $past(mode_q, 2) == tfr_pkg::MODE_POLL |-> frame_out == 0)
      else $error("frame counter moved in polling mode");
endmodule // tfr_recorder_sva
bind tfr_recorder tfr_recorder_sva #(.AXES(AXES), .PKT_W(PKT_W), .DEPTH(DEPTH))
   tfr_recorder_sva_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .trig_in(trig_in), .pkt_data(pkt_data),
   .trig_enable(trig_enable), .stream_valid(stream_valid),
   .stream_data(stream_data), .frame_out(frame_out));
`default_nettype wire

// >>> tfr_host.sv
// tfr_host: register-port master standing in for host software
// assumes: tasks are called between clock edges by the bench
`timescale 1ns/1ps
`default_nettype none
module tfr_host (
   input  wire logic        clk,
   output logic [7:0]       reg_addr,
   output logic [31:0]      reg_wdata,
   output logic             reg_wr,
   output logic             reg_rd,
   input  wire logic [31:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      // released data flips so a stale word never looks valid
      reg_wdata <= ~d;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
endmodule // tfr_host
`default_nettype wire

// >>> tfr_recorder_tb.sv
// tfr_recorder_tb: self-checking bench for the packet recorder
// assumes: tfr_host owns the register port, bench drives triggers
`timescale 1ns/1ps
`default_nettype none
module tfr_recorder_tb;
   // ***************************************************************
   // harness
   // ***************************************************************
   localparam int DEPTH = 128;
   logic        clk;
   logic        rst;
   logic        trig_in;
   logic [23:0] pkt_data;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic        trig_enable;
   logic        stream_valid;
   logic [31:0] stream_data;
   logic [31:0] frame_out;
   logic [31:0] rv;
   int          mismatches = 0;
   int          checks_done = 0;
   int          cycles = 0;
   tfr_recorder #(.AXES(4), .PKT_W(24), .DEPTH(DEPTH), .AW(7)) tfr_recorder_i (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .trig_in(trig_in), .pkt_data(pkt_data), .trig_enable(trig_enable),
      .stream_valid(stream_valid), .stream_data(stream_data),
      .frame_out(frame_out));
   tfr_host tfr_host_i (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ***************************************************************
   // helpers
   // ***************************************************************
   task automatic close_out();
      $display("counts: %0d checks, %0d mismatches", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         mismatches++;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      tfr_host_i.wr(a, d);
   endtask
   task automatic r(input logic [7:0] a);
      tfr_host_i.rd(a, rv);
   endtask
   task automatic fire(input logic [23:0] d, input logic sv,
                       input logic [7:0] f);
      @(posedge clk);
      trig_in <= 1'b1;
      pkt_data <= d;
      @(posedge clk);
      trig_in <= 1'b0;
      #1;
      chk({31'h0, stream_valid}, {31'h0, sv});
      if (sv)
         chk(stream_data, {f, d});
   endtask
   task automatic drain(input int n, input logic [23:0] d, input logic [7:0] f);
      for (int i = 0; i < n; i++) begin
         r(tfr_pkg::REG_READ);
         chk(rv, {f + i[7:0], d + i[23:0]});
      end
   endtask
   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_reset();
      r(tfr_pkg::REG_LENGTH);
      chk(rv, tfr_pkg::RESET_LEN);
      r(tfr_pkg::REG_STATUS);
      chk(rv & 32'h1, 32'h0);
      r(8'h1C);
      chk(rv, 32'h0);
      chk({trig_enable, frame_out[30:0]}, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_length();
      logic [31:0] req [4] = '{32'h5, 32'h21, 32'h64, 32'h3E8};
      logic [31:0] exp [4] = '{32'h20, 32'h20, 32'h60, 32'h80};
      for (int i = 0; i < 4; i++) begin
         w(tfr_pkg::REG_LENGTH, req[i]);
         r(tfr_pkg::REG_LENGTH);
         chk(rv, exp[i]);
      end
      $display("test length done");
   endtask
   task automatic t_stream();
      w(tfr_pkg::REG_CMD, 32'h1);
      w(tfr_pkg::REG_CTRL, 32'h2);
      w(tfr_pkg::REG_CMD, 32'hF02);
      fire(24'h5A5A5A, 1'b0, 8'h00);
      w(tfr_pkg::REG_CTRL, 32'hA);
      for (int i = 0; i < 258; i++)
         fire(i[23:0], 1'b1, i[7:0]);
      w(tfr_pkg::REG_CMD, 32'hF02);
      chk(frame_out, 32'h0);
      fire(24'hABCDEF, 1'b1, 8'h00);
      w(tfr_pkg::REG_CTRL, 32'hB);
      repeat (3) fire(24'h1, 1'b0, 8'h00);
      chk(frame_out, 32'h0);
      $display("test stream and poll done");
   endtask
   task automatic t_single();
      w(tfr_pkg::REG_CMD, 32'h1);
      w(tfr_pkg::REG_LENGTH, 32'h20);
      w(tfr_pkg::REG_CTRL, 32'h9);
      for (int i = 0; i < 40; i++)
         fire(24'h100 + i[23:0], 1'b0, 8'h00);
      r(tfr_pkg::REG_FILL);
      chk(rv, 32'h20);
      r(tfr_pkg::REG_CTRL);
      chk(rv & 32'h3, {30'h0, tfr_pkg::MODE_STOP});
      r(tfr_pkg::REG_STATUS);
      chk(rv & 32'h1, 32'h0);
      drain(32, 24'h100, 8'h00);
      $display("test single shot done");
   endtask
   task automatic t_ring();
      w(tfr_pkg::REG_CMD, 32'h1);
      w(tfr_pkg::REG_LENGTH, 32'h20);
      w(tfr_pkg::REG_CTRL, 32'hD);
      for (int i = 0; i < 40; i++)
         fire(24'h200 + i[23:0], 1'b0, 8'h00);
      r(tfr_pkg::REG_FILL);
      chk(rv, 32'h20);
      r(tfr_pkg::REG_READ);
      r(tfr_pkg::REG_STATUS);
      chk(rv & 32'h5, 32'h5);
      w(tfr_pkg::REG_CTRL, 32'h0);
      drain(32, 24'h208, 8'h08);
      $display("test ring done");
   endtask
   task automatic t_stop_idle();
      w(tfr_pkg::REG_LENGTH, 32'h40);
      w(tfr_pkg::REG_CTRL, 32'h9);
      repeat (5) fire(24'h7, 1'b0, 8'h00);
      w(tfr_pkg::REG_CTRL, 32'h8);
      r(tfr_pkg::REG_FILL);
      chk(rv, 32'h5);
      r(tfr_pkg::REG_STATUS);
      chk(rv & 32'h1, 32'h0);
      w(tfr_pkg::REG_CTRL, 32'hE);
      w(tfr_pkg::REG_CMD, 32'h1);
      chk({31'h0, trig_enable}, 32'h0);
      r(tfr_pkg::REG_CTRL);
      chk(rv & 32'hF, 32'h0);
      fire(24'h3, 1'b0, 8'h00);
      $display("test stop and idle done");
   endtask
   initial begin
      rst = 1'b1;
      trig_in = 1'b0;
      pkt_data = 24'h0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_length();
      t_stream();
      t_single();
      t_ring();
      t_stop_idle();
      close_out();
   end
endmodule // tfr_recorder_tb
`default_nettype wire
